//--- design/mba_pkg.sv
// Package: constants and carrier types of the Modbus ASCII read/write and exception handler
`default_nettype none
package mba_pkg;
    // Frame characters
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [7:0] CH_0     = 8'h30;
    localparam logic [7:0] CH_9     = 8'h39;
    localparam logic [7:0] CH_A     = 8'h41;
    localparam logic [7:0] CH_F     = 8'h46;
    localparam logic [7:0] HEX_TEN  = 8'h0A;
    // Function and error codes
    localparam logic [7:0] FN_RDWR  = 8'h17;
    localparam logic [7:0] EXC_BIT  = 8'h80;
    localparam logic [7:0] ERR_FUNC = 8'h01;
    localparam logic [7:0] ERR_ADDR = 8'h02;
    localparam logic [7:0] ERR_DATA = 8'h03;
    // Implemented register window
    localparam logic [15:0] ADDR_MIN = 16'h0040;
    localparam logic [15:0] ADDR_MAX = 16'h0058;
    // Byte positions in a function 17 request
    localparam int POS_ADR  = 0;
    localparam int POS_FN   = 1;
    localparam int POS_RADR = 2;
    localparam int POS_RCNT = 4;
    localparam int POS_WADR = 6;
    localparam int POS_WCNT = 8;
    localparam int POS_BCNT = 10;
    localparam int POS_WDAT = 11;
    localparam int RQ_FIXED = 12;
    // Response header: address, function, byte count or error code
    localparam int RD_HDR   = 3;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_RECV   = 4'h1,
        ST_LFWAIT = 4'h2,
        ST_CHECK  = 4'h3,
        ST_WRITE  = 4'h4,
        ST_READ   = 4'h5,
        ST_RDLAT  = 4'h6,
        ST_SOF    = 4'h7,
        ST_HI     = 4'h8,
        ST_LO     = 4'h9,
        ST_CHK_HI = 4'hA,
        ST_CHK_LO = 4'hB,
        ST_CR     = 4'hC,
        ST_LF     = 4'hD,
        ST_DONE   = 4'hE
    } mba_state_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } mba_char_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mba_reg_type;
endpackage
`default_nettype wire

//--- design/mba_handler.sv
// Module: Modbus ASCII slave request handler for function 17 and exception replies
//
// Summary of operation
// - Request fields: read adr/cnt, write adr/cnt, bytes, data
// - Byte count is twice write count; words written
// - Reply echoes function, byte count, read words
// - Unsupported function answered with error 01
// - Register address out of range gives error 02
// - Malformed data field gives error 03
// - Exception function code is request code plus 80H
// - Exception frame: address, function, error, LRC
// - Start address 0100H is out of range
`timescale 1ns/1ps
`default_nettype none
module mba_handler #(
    parameter int DEPTH    = 64,
    parameter int MAX_REGS = 16
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic [7:0]            slave_addr,
    input  wire mba_pkg::mba_char_type rx,
    input  wire logic                  tx_ready,
    output var  mba_pkg::mba_char_type tx,
    output var  mba_pkg::mba_reg_type  reg_req,
    input  wire logic [15:0]           reg_rdata
);
    localparam int IW = $clog2(DEPTH);

    mba_pkg::mba_state_type state_ff, nxt_state;
    mba_pkg::mba_char_type  tx_ff, nxt_tx;
    mba_pkg::mba_reg_type   reg_ff, nxt_reg;
    logic [7:0]    buf_ff [DEPTH];
    logic [IW:0]   cnt_ff, nxt_cnt, idx_ff, nxt_idx, len_ff, nxt_len;
    logic [3:0]    hi_ff, nxt_hi;
    logic          half_ff, nxt_half, exc_ff, nxt_exc;
    logic [7:0]    lrc_ff, nxt_lrc;
    logic          we0, we1;
    logic [IW-1:0] wa0, wa1;
    logic [7:0]    wd0, wd1, cur, lrc_neg;
    logic [4:0]    hv;
    logic          go, lrc_ok, len_ok, rng_ok, fn_ok, chk_go;
    logic [15:0]   rd_adr, rd_cnt, wr_adr, wr_cnt;
    // Read span kept aside; reply data overwrites its bytes in the buffer
    logic [15:0]   rda_ff, nxt_rda, rdc_ff, nxt_rdc;
    logic [7:0]    bcnt;

    // Returns {is_hex, nibble}; upper-case digits only, as the line uses
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= mba_pkg::CH_0 && c <= mba_pkg::CH_9) return {1'b1, c[3:0]};
        if (c >= mba_pkg::CH_A && c <= mba_pkg::CH_F) return {1'b1, c[3:0] + 4'h9};
        return 5'h00;
    endfunction

    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        if ({4'h0, n} < mba_pkg::HEX_TEN) return mba_pkg::CH_0 + {4'h0, n};
        return mba_pkg::CH_A - mba_pkg::HEX_TEN + {4'h0, n};
    endfunction

    assign rd_adr  = {buf_ff[mba_pkg::POS_RADR], buf_ff[mba_pkg::POS_RADR+1]};
    assign rd_cnt  = {buf_ff[mba_pkg::POS_RCNT], buf_ff[mba_pkg::POS_RCNT+1]};
    assign wr_adr  = {buf_ff[mba_pkg::POS_WADR], buf_ff[mba_pkg::POS_WADR+1]};
    assign wr_cnt  = {buf_ff[mba_pkg::POS_WCNT], buf_ff[mba_pkg::POS_WCNT+1]};
    assign bcnt    = buf_ff[mba_pkg::POS_BCNT];
    assign cur     = buf_ff[idx_ff[IW-1:0]];
    assign lrc_neg = ~lrc_ff + 8'h01;
    assign go      = !tx_ff.valid || tx_ready;
    assign hv      = hex_val(rx.data);
    // Sum over address..LRC is zero when the LRC matches
    assign lrc_ok  = lrc_ff == 8'h00 && !half_ff && cnt_ff > (IW+1)'(2);
    assign fn_ok   = buf_ff[mba_pkg::POS_FN] == mba_pkg::FN_RDWR;
    assign chk_go  = state_ff == mba_pkg::ST_CHECK && lrc_ok
                     && buf_ff[mba_pkg::POS_ADR] == slave_addr;
    // Counts are capped so read data and write data both fit the buffer
    assign len_ok  = rd_cnt != 16'h0000 && int'(rd_cnt) <= MAX_REGS
                     && wr_cnt != 16'h0000 && int'(wr_cnt) <= MAX_REGS
                     && {8'h00, bcnt} == {wr_cnt[14:0], 1'b0}
                     && int'(cnt_ff) == mba_pkg::RQ_FIXED + int'(bcnt);
    assign rng_ok  = rd_adr >= mba_pkg::ADDR_MIN && wr_adr >= mba_pkg::ADDR_MIN
                     && {1'b0, rd_adr} + {1'b0, rd_cnt} <= {1'b0, mba_pkg::ADDR_MAX} + 17'h00001
                     && {1'b0, wr_adr} + {1'b0, wr_cnt} <= {1'b0, mba_pkg::ADDR_MAX} + 17'h00001;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_idx   = idx_ff;
        nxt_len   = len_ff;
        nxt_hi    = hi_ff;
        nxt_half  = half_ff;
        nxt_exc   = exc_ff;
        nxt_lrc   = lrc_ff;
        nxt_rda   = rda_ff;
        nxt_rdc   = rdc_ff;
        nxt_tx    = '{valid: tx_ff.valid && !tx_ready, data: tx_ff.data};
        nxt_reg   = '{wr: 1'b0, rd: 1'b0, addr: reg_ff.addr, wdata: reg_ff.wdata};
        we0 = 1'b0;
        we1 = 1'b0;
        wa0 = '0;
        wa1 = '0;
        wd0 = 8'h00;
        wd1 = 8'h00;
        case (state_ff)
            mba_pkg::ST_IDLE: begin
                if (rx.valid && rx.data == mba_pkg::CH_COLON) begin
                    nxt_cnt   = '0;
                    nxt_lrc   = 8'h00;
                    nxt_half  = 1'b0;
                    nxt_state = mba_pkg::ST_RECV;
                end
            end
            mba_pkg::ST_RECV: begin
                if (rx.valid) begin
                    if (hv[4] && !half_ff) begin
                        nxt_hi   = hv[3:0];
                        nxt_half = 1'b1;
                    end else if (hv[4]) begin
                        nxt_half = 1'b0;
                        if (int'(cnt_ff) == DEPTH) begin
                            nxt_state = mba_pkg::ST_IDLE;
                        end else begin
                            we0     = 1'b1;
                            wa0     = cnt_ff[IW-1:0];
                            wd0     = {hi_ff, hv[3:0]};
                            nxt_lrc = lrc_ff + {hi_ff, hv[3:0]};
                            nxt_cnt = cnt_ff + (IW+1)'(1);
                        end
                    end else if (rx.data == mba_pkg::CH_COLON) begin
                        // A fresh colon restarts the frame
                        nxt_cnt  = '0;
                        nxt_lrc  = 8'h00;
                        nxt_half = 1'b0;
                    end else if (rx.data == mba_pkg::CH_CR) begin
                        nxt_state = mba_pkg::ST_LFWAIT;
                    end else begin
                        nxt_state = mba_pkg::ST_IDLE;
                    end
                end
            end
            mba_pkg::ST_LFWAIT: begin
                if (rx.valid) begin
                    nxt_state = rx.data == mba_pkg::CH_LF ? mba_pkg::ST_CHECK : mba_pkg::ST_IDLE;
                end
            end
            mba_pkg::ST_CHECK: begin
                nxt_state = mba_pkg::ST_IDLE;
                if (chk_go) begin
                    nxt_idx   = '0;
                    nxt_len   = (IW+1)'(mba_pkg::RD_HDR);
                    nxt_exc   = 1'b1;
                    nxt_state = mba_pkg::ST_SOF;
                    we0 = 1'b1;
                    wa0 = IW'(mba_pkg::POS_FN);
                    wd0 = buf_ff[mba_pkg::POS_FN] | mba_pkg::EXC_BIT;
                    we1 = 1'b1;
                    wa1 = IW'(mba_pkg::RD_HDR - 1);
                    if (!fn_ok) begin
                        wd1 = mba_pkg::ERR_FUNC;
                    end else if (!len_ok) begin
                        wd1 = mba_pkg::ERR_DATA;
                    end else if (!rng_ok) begin
                        wd1 = mba_pkg::ERR_ADDR;
                    end else begin
                        we0       = 1'b0;
                        we1       = 1'b0;
                        nxt_exc   = 1'b0;
                        nxt_rda   = rd_adr;
                        nxt_rdc   = rd_cnt;
                        nxt_state = mba_pkg::ST_WRITE;
                    end
                end
            end
            mba_pkg::ST_WRITE: begin
                // Writes finish before reads reuse the buffer tail
                if (16'(idx_ff) == wr_cnt) begin
                    nxt_idx   = '0;
                    nxt_state = mba_pkg::ST_READ;
                end else begin
                    nxt_reg.wr    = 1'b1;
                    nxt_reg.addr  = wr_adr + 16'(idx_ff);
                    nxt_reg.wdata = {buf_ff[mba_pkg::POS_WDAT + 2*int'(idx_ff)],
                                     buf_ff[mba_pkg::POS_WDAT + 2*int'(idx_ff) + 1]};
                    nxt_idx       = idx_ff + (IW+1)'(1);
                end
            end
            mba_pkg::ST_READ: begin
                if (16'(idx_ff) == rdc_ff) begin
                    nxt_idx   = '0;
                    nxt_len   = (IW+1)'(mba_pkg::RD_HDR + 2*int'(rdc_ff));
                    we0       = 1'b1;
                    wa0       = IW'(mba_pkg::RD_HDR - 1);
                    wd0       = {rdc_ff[6:0], 1'b0};
                    nxt_state = mba_pkg::ST_SOF;
                end else begin
                    nxt_reg.rd   = 1'b1;
                    nxt_reg.addr = rda_ff + 16'(idx_ff);
                    nxt_state    = mba_pkg::ST_RDLAT;
                end
            end
            mba_pkg::ST_RDLAT: begin
                we0       = 1'b1;
                wa0       = IW'(mba_pkg::RD_HDR + 2*int'(idx_ff));
                wd0       = reg_rdata[15:8];
                we1       = 1'b1;
                wa1       = IW'(mba_pkg::RD_HDR + 2*int'(idx_ff) + 1);
                wd1       = reg_rdata[7:0];
                nxt_idx   = idx_ff + (IW+1)'(1);
                nxt_state = mba_pkg::ST_READ;
            end
            mba_pkg::ST_SOF: begin
                if (go) begin
                    nxt_tx    = '{valid: 1'b1, data: mba_pkg::CH_COLON};
                    nxt_lrc   = 8'h00;
                    nxt_state = mba_pkg::ST_HI;
                end
            end
            mba_pkg::ST_HI: begin
                if (go) begin
                    nxt_tx    = '{valid: 1'b1, data: hex_chr(cur[7:4])};
                    nxt_lrc   = lrc_ff + cur;
                    nxt_state = mba_pkg::ST_LO;
                end
            end
            mba_pkg::ST_LO: begin
                if (go) begin
                    nxt_tx    = '{valid: 1'b1, data: hex_chr(cur[3:0])};
                    nxt_idx   = idx_ff + (IW+1)'(1);
                    nxt_state = idx_ff + (IW+1)'(1) == len_ff ? mba_pkg::ST_CHK_HI : mba_pkg::ST_HI;
                end
            end
            mba_pkg::ST_CHK_HI: begin
                if (go) begin
                    nxt_tx    = '{valid: 1'b1, data: hex_chr(lrc_neg[7:4])};
                    nxt_state = mba_pkg::ST_CHK_LO;
                end
            end
            mba_pkg::ST_CHK_LO: begin
                if (go) begin
                    nxt_tx    = '{valid: 1'b1, data: hex_chr(lrc_neg[3:0])};
                    nxt_state = mba_pkg::ST_CR;
                end
            end
            mba_pkg::ST_CR: begin
                if (go) begin
                    nxt_tx    = '{valid: 1'b1, data: mba_pkg::CH_CR};
                    nxt_state = mba_pkg::ST_LF;
                end
            end
            mba_pkg::ST_LF: begin
                if (go) begin
                    nxt_tx    = '{valid: 1'b1, data: mba_pkg::CH_LF};
                    nxt_state = mba_pkg::ST_DONE;
                end
            end
            mba_pkg::ST_DONE: begin
                if (go) begin
                    nxt_state = mba_pkg::ST_IDLE;
                end
            end
            default: nxt_state = mba_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= mba_pkg::ST_IDLE;
            cnt_ff   <= '0;
            idx_ff   <= '0;
            len_ff   <= '0;
            hi_ff    <= 4'h0;
            half_ff  <= 1'b0;
            exc_ff   <= 1'b0;
            lrc_ff   <= 8'h00;
            rda_ff   <= 16'h0000;
            rdc_ff   <= 16'h0000;
            tx_ff    <= '0;
            reg_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            idx_ff   <= nxt_idx;
            len_ff   <= nxt_len;
            hi_ff    <= nxt_hi;
            half_ff  <= nxt_half;
            exc_ff   <= nxt_exc;
            lrc_ff   <= nxt_lrc;
            rda_ff   <= nxt_rda;
            rdc_ff   <= nxt_rdc;
            tx_ff    <= nxt_tx;
            reg_ff   <= nxt_reg;
        end
    end

    // Frame buffer needs no reset; contents are only read after being written
    always_ff @(posedge mclk) begin
        if (we0) buf_ff[wa0] <= wd0;
        if (we1) buf_ff[wa1] <= wd1;
    end

    assign tx      = tx_ff;
    assign reg_req = reg_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_lrc_drop;
        state_ff == mba_pkg::ST_CHECK && !lrc_ok |=> state_ff == mba_pkg::ST_IDLE ##1 !tx_ff.valid;
    endproperty
    a_lrc_drop: assert property (p_lrc_drop) else $error("bad LRC frame answered");
    property p_func;
        chk_go && !fn_ok |=> exc_ff && buf_ff[2] == mba_pkg::ERR_FUNC;
    endproperty
    a_func: assert property (p_func) else $error("wrong code for bad function");
    property p_data;
        chk_go && fn_ok && !len_ok |=> exc_ff && buf_ff[2] == mba_pkg::ERR_DATA;
    endproperty
    a_data: assert property (p_data) else $error("wrong code for bad data");
    property p_addr;
        chk_go && fn_ok && len_ok && !rng_ok |=> exc_ff && buf_ff[2] == mba_pkg::ERR_ADDR;
    endproperty
    a_addr: assert property (p_addr) else $error("wrong code for bad address");
    property p_oor;
        chk_go && fn_ok && len_ok && rd_adr > mba_pkg::ADDR_MAX |=> exc_ff ##1 !reg_ff.rd;
    endproperty
    a_oor: assert property (p_oor) else $error("out of range read not refused");
    property p_excfn;
        chk_go && !(fn_ok && len_ok && rng_ok)
        |=> buf_ff[1] == ($past(buf_ff[1]) | mba_pkg::EXC_BIT);
    endproperty
    a_excfn: assert property (p_excfn) else $error("exception function not marked");
    property p_exclen;
        state_ff == mba_pkg::ST_SOF && exc_ff |-> int'(len_ff) == mba_pkg::RD_HDR;
    endproperty
    a_exclen: assert property (p_exclen) else $error("exception frame length wrong");
    property p_rdlen;
        state_ff == mba_pkg::ST_SOF && !exc_ff
        |-> int'(len_ff) == mba_pkg::RD_HDR + 2*int'(rdc_ff) && buf_ff[2] == {rdc_ff[6:0], 1'b0};
    endproperty
    a_rdlen: assert property (p_rdlen) else $error("read reply byte count wrong");
    property p_wr;
        reg_ff.wr |-> reg_ff.addr >= wr_adr && {1'b0, reg_ff.addr} < {1'b0, wr_adr} + {1'b0, wr_cnt};
    endproperty
    a_wr: assert property (p_wr) else $error("write outside requested span");
    property p_sof;
        state_ff == mba_pkg::ST_SOF && go |=> tx_ff.valid && tx_ff.data == mba_pkg::CH_COLON;
    endproperty
    a_sof: assert property (p_sof) else $error("reply not opened by colon");
endmodule // mba_handler
`default_nettype wire

//--- bench/mba_regs_model.sv
// Register file model standing behind the handler's register port
`timescale 1ns/1ps
`default_nettype none
module mba_regs_model (
    input  wire mba_pkg::mba_reg_type reg_req,
    input  wire logic                 mclk,
    output var  logic [15:0]          reg_rdata
);
    logic [15:0] mem [0:255];

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
        mem[8'h40] = 16'h09E1;
        mem[8'h41] = 16'hFC22;
        mem[8'h42] = 16'hFC22;
    end

    always @(posedge mclk) begin
        if (reg_req.wr) begin
            mem[reg_req.addr[7:0]] <= reg_req.wdata;
        end
    end

    // Read data stands only while rd is high; otherwise inverted so stale use shows
    always_comb begin
        if (reg_req.rd) begin
            reg_rdata = mem[reg_req.addr[7:0]];
        end else begin
            reg_rdata = ~mem[reg_req.addr[7:0]];
        end
    end
endmodule // mba_regs_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking testbench of the Modbus ASCII function 17 and exception handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
    typedef logic [7:0] mba_bytes_type [$];

    logic                  mclk = 1'b0;
    logic                  rst = 1'b1;
    logic [7:0]            slave_addr = 8'h01;
    mba_pkg::mba_char_type rx = '0;
    logic                  tx_ready = 1'b1;
    mba_pkg::mba_char_type tx;
    mba_pkg::mba_reg_type  reg_req;
    logic [15:0]           reg_rdata;
    int                    errors = 0;
    int                    checks = 0;
    int                    wr_cnt = 0;

    mba_handler mba_handler_inst (
        .mclk      (mclk),
        .rst       (rst),
        .slave_addr(slave_addr),
        .rx        (rx),
        .tx_ready  (tx_ready),
        .tx        (tx),
        .reg_req   (reg_req),
        .reg_rdata (reg_rdata)
    );

    mba_regs_model mba_regs_model_inst (
        .reg_req  (reg_req),
        .mclk     (mclk),
        .reg_rdata(reg_rdata)
    );

    always #5 mclk = ~mclk;

    always @(posedge mclk) begin
        if (reg_req.wr === 1'b1) begin
            wr_cnt++;
        end
    end

    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction

    // Whole frame in characters; LRC computed here, optionally spoiled
    task automatic build(input mba_bytes_type b, input logic bad, output mba_bytes_type c);
        logic [7:0] s;
        s = 8'h00;
        c = {mba_pkg::CH_COLON};
        foreach (b[i]) begin
            s = s + b[i];
            c.push_back(hx(b[i][7:4]));
            c.push_back(hx(b[i][3:0]));
        end
        s = 8'h00 - s;
        s = s ^ {7'h00, bad};
        c.push_back(hx(s[7:4]));
        c.push_back(hx(s[3:0]));
        c.push_back(mba_pkg::CH_CR);
        c.push_back(mba_pkg::CH_LF);
    endtask

    task automatic send_frame(input mba_bytes_type b, input logic bad);
        mba_bytes_type c;
        build(b, bad, c);
        foreach (c[i]) begin
            rx = {1'b1, c[i]};
            @(posedge mclk);
            #1;
        end
        rx = '0;
    endtask

    // Slow mode toggles tx_ready so every other cycle stalls the reply
    task automatic expect_reply(input mba_bytes_type b, input logic slow);
        mba_bytes_type c;
        int            n;
        logic          got;
        build(b, 1'b0, c);
        for (int i = 0; i < c.size(); i++) begin
            n = 0;
            got = 1'b0;
            while (!got && n < 500) begin
                @(posedge mclk);
                #1;
                tx_ready = slow ? ~tx_ready : 1'b1;
                got = (tx.valid === 1'b1) && tx_ready;
                n++;
            end
            if (got) begin
                `CHK(tx.data, c[i]);
            end else begin
                `CHK(tx.valid, 1'b1);
                i = c.size();
            end
        end
        tx_ready = 1'b1;
        // Let the last character go so the next frame finds the handler idle
        @(posedge mclk);
        #1;
    endtask

    task automatic expect_silence;
        repeat (60) begin
            @(posedge mclk);
            #1;
            `CHK(tx.valid, 1'b0);
        end
    endtask

    task automatic t_normal;
        int w0;
        w0 = wr_cnt;
        send_frame('{8'h01, 8'h17, 8'h00, 8'h40, 8'h00, 8'h03, 8'h00, 8'h51, 8'h00, 8'h02,
                     8'h04, 8'h0B, 8'hB8, 8'h00, 8'h32}, 1'b0);
        expect_reply('{8'h01, 8'h17, 8'h06, 8'h09, 8'hE1, 8'hFC, 8'h22, 8'hFC, 8'h22},
                     1'b0);
        `CHK(wr_cnt - w0, 2);
        `CHK(mba_regs_model_inst.mem[8'h51], 16'h0BB8);
        `CHK(mba_regs_model_inst.mem[8'h52], 16'h0032);
        $display("test normal read write done");
    endtask

    task automatic t_bad_func;
        int w0;
        w0 = wr_cnt;
        send_frame('{8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h07}, 1'b0);
        expect_reply('{8'h01, 8'h83, 8'h01}, 1'b1);
        `CHK(wr_cnt - w0, 0);
        $display("test unsupported function done");
    endtask

    task automatic t_bad_addr;
        int w0;
        w0 = wr_cnt;
        send_frame('{8'h01, 8'h17, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h51, 8'h00, 8'h01,
                     8'h02, 8'h12, 8'h34}, 1'b0);
        expect_reply('{8'h01, 8'h97, 8'h02}, 1'b0);
        `CHK(wr_cnt - w0, 0);
        $display("test address out of range done");
    endtask

    task automatic t_bad_data;
        int w0;
        w0 = wr_cnt;
        // Byte count three against two words: length agrees, count does not
        send_frame('{8'h01, 8'h17, 8'h00, 8'h40, 8'h00, 8'h01, 8'h00, 8'h51, 8'h00, 8'h02,
                     8'h03, 8'h0B, 8'hB8, 8'h00}, 1'b0);
        expect_reply('{8'h01, 8'h97, 8'h03}, 1'b0);
        `CHK(wr_cnt - w0, 0);
        $display("test malformed data done");
    endtask

    task automatic t_dropped;
        int w0;
        w0 = wr_cnt;
        send_frame('{8'h01, 8'h17, 8'h00, 8'h40, 8'h00, 8'h01, 8'h00, 8'h53, 8'h00, 8'h01,
                     8'h02, 8'hAA, 8'h55}, 1'b1);
        expect_silence();
        send_frame('{8'h02, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, 1'b0);
        expect_silence();
        `CHK(wr_cnt - w0, 0);
        $display("test dropped frames done");
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole sequence needs under five hundred cycles; forty times that is a hang
    initial begin
        #200000;
        errors++;
        results();
    end

    initial begin
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'b0;
        `CHK(tx.valid, 1'b0);
        t_normal();
        t_bad_func();
        t_bad_addr();
        t_bad_data();
        t_dropped();
        t_normal();
        results();
    end
endmodule // testbench
`undef CHK
`default_nettype wire
